// ---- hdl/ddc_pkg.sv ----
// package for the device disable control block: states, carriers, constants
// assumes one 200 MHz core clock and an nvm loader that reports load completion
package ddc_pkg;

    localparam logic [1:0] DDC_SYNC_RESET  = 2'h3; // synchroniser resets to deasserted
    localparam logic       DDC_ALLOW_RESET = 1'h0; // permission off after reset
    localparam logic       DDC_PERST_RESET = 1'h0; // reset history starts low: high counts as release

    typedef enum logic [3:0] {
        DDC_ST_WAIT_NVM = 4'h1, // nvm not yet read: request ignored
        DDC_ST_ACTIVE   = 4'h2, // normal operation
        DDC_ST_DISABLED = 4'h4, // device disable mode
        DDC_ST_REREAD   = 4'h8  // fundamental reset released, nvm being reread
    } ddc_state_e;

    // controls that go to the rest of the chip
    typedef struct packed {
        logic link_l3;
        logic phy_power_down;
        logic output_hiz;
        logic disabled;
    } ddc_ctrl_s;

    localparam ddc_ctrl_s  DDC_CTRL_RESET  = 4'h0; // chip runs: nothing parked or released

    typedef struct packed {
        ddc_state_e state;
        logic       allow;
        logic       perst_seen; // fundamental reset level one cycle ago
        ddc_ctrl_s  ctrl;
    } ddc_core_s;

endpackage : ddc_pkg

// ---- hdl/ddc_sync.sv ----
// two flip-flop level synchroniser for the disable request pin
// assumes the pin may change at any time relative to sys_clk
`timescale 1ns/1ps
module ddc_sync (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [1:0] stages;

    // first stage feeds only the second; resets high so the pin reads deasserted
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stages <= ddc_pkg::DDC_SYNC_RESET;
        end else begin
            stages <= {stages[0], async_in};
        end
    end

    assign sync_out = stages[1];
endmodule : ddc_sync

// ---- hdl/ddc_top.sv ----
// device disable control: mode machine driving link, phy and pad controls
// assumes nvm_loaded pulses or holds high once the nvm image has been read,
// and link_fundamental_reset_n is synchronous to sys_clk
`timescale 1ns/1ps
module ddc_top (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic disable_request_n,        // pad pulls it high when open
    input  wire logic link_fundamental_reset_n,
    input  wire logic nvm_loaded,
    input  wire logic nvm_disable_allow,        // allow bit from the nvm image
    output logic      link_l3,
    output logic      phy_power_down,
    output logic      output_hiz,
    output logic      device_disabled
);
    // request after the synchroniser, still active low
    logic               req_sync_n;
    // state of the block apart from the synchroniser stages: mode, permission, reset history, controls
    ddc_pkg::ddc_core_s core;
    ddc_pkg::ddc_core_s next_core;

    // release of the fundamental reset: high now, low one cycle ago
    function automatic logic perst_rising(
        input logic level_now,
        input logic level_before
    );
        return level_now & ~level_before;
    endfunction : perst_rising

    // entry needs the request low and the permission from the image
    function automatic logic entry_wanted(
        input logic request_n,
        input logic permit
    );
        return ~request_n & permit;
    endfunction : entry_wanted

    // pad and link controls for a mode; all move together so none lags
    function automatic ddc_pkg::ddc_ctrl_s ctrl_for(
        input ddc_pkg::ddc_state_e mode
    );
        ddc_pkg::ddc_ctrl_s ctrl;
        ctrl = ddc_pkg::DDC_CTRL_RESET;
        case (mode)
            ddc_pkg::DDC_ST_DISABLED: begin
                // link parked, phy off and pads released in the same cycle
                ctrl.link_l3        = 1'h1;
                ctrl.phy_power_down = 1'h1;
                ctrl.output_hiz     = 1'h1;
                ctrl.disabled       = 1'h1;
            end
            ddc_pkg::DDC_ST_WAIT_NVM: begin
                // power-up: the chip comes up normally while the image loads
                ctrl = ddc_pkg::DDC_CTRL_RESET;
            end
            ddc_pkg::DDC_ST_ACTIVE: begin
                // normal operation
                ctrl = ddc_pkg::DDC_CTRL_RESET;
            end
            ddc_pkg::DDC_ST_REREAD: begin
                // brief exit: the pads drive again until the image is reread
                ctrl = ddc_pkg::DDC_CTRL_RESET;
            end
            default: begin
                ctrl = ddc_pkg::DDC_CTRL_RESET;
            end
        endcase
        return ctrl;
    endfunction : ctrl_for

    // request is asynchronous, so it is synchronised before use
    ddc_sync u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (disable_request_n),
        .sync_out (req_sync_n)
    );

    // mode machine; the registered copy drives every output
    always_comb begin
        next_core = core;
        // permission refreshed on every image read; reset leaves it off
        if (nvm_loaded) begin
            next_core.allow = nvm_disable_allow;
        end
        // one cycle of reset history for the release detector
        next_core.perst_seen = link_fundamental_reset_n;
        case (core.state)
            ddc_pkg::DDC_ST_WAIT_NVM: begin
                // the pin means nothing until the image has been read
                if (nvm_loaded) begin
                    next_core.state = ddc_pkg::DDC_ST_ACTIVE;
                end else begin
                    next_core.state = ddc_pkg::DDC_ST_WAIT_NVM;
                end
            end
            ddc_pkg::DDC_ST_ACTIVE: begin
                // an open pin reads high through the pull-up, so stays here
                if (entry_wanted(req_sync_n, core.allow)) begin
                    next_core.state = ddc_pkg::DDC_ST_DISABLED;
                end else if (perst_rising(link_fundamental_reset_n, core.perst_seen)) begin
                    // a link reset reloads the image; wait for it
                    next_core.state = ddc_pkg::DDC_ST_REREAD;
                end else begin
                    next_core.state = ddc_pkg::DDC_ST_ACTIVE;
                end
            end
            ddc_pkg::DDC_ST_DISABLED: begin
                // releasing the request ends the mode and a reset release leaves it briefly; reset assertion is ignored
                if (req_sync_n) begin
                    next_core.state = ddc_pkg::DDC_ST_ACTIVE;
                end else if (perst_rising(link_fundamental_reset_n, core.perst_seen)) begin
                    // momentary exit while the image is reread
                    next_core.state = ddc_pkg::DDC_ST_REREAD;
                end else begin
                    next_core.state = ddc_pkg::DDC_ST_DISABLED;
                end
            end
            ddc_pkg::DDC_ST_REREAD: begin
                // the fresh allow bit is used, the latched one may be stale
                if (!nvm_loaded) begin
                    next_core.state = ddc_pkg::DDC_ST_REREAD;
                end else if (entry_wanted(req_sync_n, nvm_disable_allow)) begin
                    next_core.state = ddc_pkg::DDC_ST_DISABLED;
                end else begin
                    next_core.state = ddc_pkg::DDC_ST_ACTIVE;
                end
            end
            default: begin
                // an illegal code restarts from the power-up wait
                next_core.state = ddc_pkg::DDC_ST_WAIT_NVM;
            end
        endcase
        // controls follow the next state, so outputs come straight from flops
        next_core.ctrl = ctrl_for(next_core.state);
    end

    // state register; reset leaves the machine waiting for the image
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            core.state      <= ddc_pkg::DDC_ST_WAIT_NVM;
            core.allow      <= ddc_pkg::DDC_ALLOW_RESET;
            core.perst_seen <= ddc_pkg::DDC_PERST_RESET;
            core.ctrl       <= ddc_pkg::DDC_CTRL_RESET;
        end else begin
            core <= next_core;
        end
    end

    // outputs are the registered controls, no logic after the flops
    assign link_l3         = core.ctrl.link_l3;
    assign phy_power_down  = core.ctrl.phy_power_down;
    assign output_hiz      = core.ctrl.output_hiz;
    assign device_disabled = core.ctrl.disabled;
endmodule : ddc_top

// ---- testbench/ddc_platform.sv ----
// platform side model that drives the disable request pin
// assumes the pad pull-up wins whenever the pin is released
`timescale 1ns/1ps
module ddc_platform (
    input  wire logic drive_en,
    input  wire logic level,
    output wire logic pin
);
    // a released pin floats up, so the device runs by default
    assign pin = drive_en ? level : 1'h1;
endmodule : ddc_platform

// ---- testbench/ddc_top_monitor.sv ----
// assertions on the ports of ddc_top, bound at the foot
// assumes one clock and an async active-high reset
`timescale 1ns/1ps
module ddc_top_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic disable_request_n,
    input wire logic link_fundamental_reset_n,
    input wire logic nvm_loaded,
    input wire logic nvm_disable_allow,
    input wire logic link_l3,
    input wire logic phy_power_down,
    input wire logic output_hiz,
    input wire logic device_disabled
);
    logic nvm_seen;
    logic allow_seen;
    // nvm history since reset: read at all, and last allow bit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nvm_seen   <= 1'h0;
            allow_seen <= 1'h0;
        end else begin
            nvm_seen   <= nvm_seen | nvm_loaded;
            allow_seen <= nvm_loaded ? nvm_disable_allow : allow_seen;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_enter_held_req: assert property (
        (nvm_loaded && nvm_disable_allow && !disable_request_n && link_fundamental_reset_n)[*4]
        |=> device_disabled) else $error("no entry on held request");
    a_high_req_runs: assert property (
        disable_request_n[*3] |=> !device_disabled) else $error("disabled with request high");
    a_allow_gates: assert property (
        $rose(device_disabled) |-> $past(allow_seen | (nvm_loaded & nvm_disable_allow)))
        else $error("entry without allow");
    a_ctrl_agree: assert property (
        {link_l3, phy_power_down, output_hiz} == {3{device_disabled}})
        else $error("controls split");
    a_perst_no_effect: assert property (
        device_disabled && !disable_request_n && $past(!disable_request_n)
        && $past(!disable_request_n, 2) && !$rose(link_fundamental_reset_n)
        |=> device_disabled) else $error("left on reset");
    a_release_reread: assert property (
        $rose(link_fundamental_reset_n) && device_disabled |=> !device_disabled)
        else $error("no reread exit");
    a_wait_nvm: assert property (
        !nvm_seen |=> !device_disabled) else $error("entry before nvm read");
    a_sync_delay: assert property (
        $rose(device_disabled) |-> $past(!disable_request_n, 3)) else $error("entry too early");
endmodule : ddc_top_monitor
bind ddc_top ddc_top_monitor u_ddc_top_monitor (.sys_clk(sys_clk), .rst(rst),
    .disable_request_n(disable_request_n), .link_fundamental_reset_n(link_fundamental_reset_n),
    .nvm_loaded(nvm_loaded), .nvm_disable_allow(nvm_disable_allow), .link_l3(link_l3),
    .phy_power_down(phy_power_down), .output_hiz(output_hiz), .device_disabled(device_disabled));

// ---- testbench/ddc_top_bench.sv ----
// self-checking bench for ddc_top with the platform pin model
// assumes 200 MHz sys_clk; expected mode is allow and request, settled
`timescale 1ns/1ps
module ddc_top_bench;
    logic sys_clk, rst, en, lvl, perst_n, ld, allow, req_n, l3, pd, hiz, dis;
    int   err_count, comparisons, cyc, seed, r;
    int   m_mode, m_allow, m_perst, m_req, rel, req_q[$];
    ddc_top u_ddc_top (.sys_clk(sys_clk), .rst(rst), .disable_request_n(req_n),
        .link_fundamental_reset_n(perst_n), .nvm_loaded(ld), .nvm_disable_allow(allow),
        .link_l3(l3), .phy_power_down(pd), .output_hiz(hiz), .device_disabled(dis));
    ddc_platform u_ddc_platform (.drive_en(en), .level(lvl), .pin(req_n));
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // reference model: 0 wait, 1 run, 2 disabled, 3 reread; queue is the sync delay
    always @(posedge sys_clk) begin
        if (rst) begin
            m_mode = 0;
            m_allow = 0;
            m_perst = 0;
            req_q.delete();
            req_q.push_back(1);
            req_q.push_back(1);
        end else begin
            m_req = req_q.pop_front();
            req_q.push_back(int'(req_n));
            rel = perst_n && !m_perst;
            case (m_mode)
                0: m_mode = ld ? 1 : 0;
                1: m_mode = (!m_req && m_allow) ? 2 : (rel ? 3 : 1);
                2: m_mode = m_req ? 1 : (rel ? 3 : 2);
                3: m_mode = !ld ? 3 : ((!m_req && allow) ? 2 : 1);
                default: m_mode = 0;
            endcase
            m_allow = ld ? int'(allow) : m_allow;
            m_perst = perst_n;
        end
    end
    // hang guard: the whole run needs under two hundred cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // platform drives low and releases for high, so high is the pull-up
    task automatic step(input logic q, input logic p, input logic l, input logic a, input int n);
        en <= ~q;
        lvl <= q;
        perst_n <= p;
        ld <= l;
        allow <= a;
        repeat (n) @(posedge sys_clk);
    endtask : step
    // outputs read at the falling edge, clear of the edge that moves them
    task automatic chk(input logic e);
        @(negedge sys_clk);
        comparisons++;
        if ({l3, pd, hiz, dis} !== {4{e}}) begin
            err_count++;
            $display("ERROR %0t mode mismatch", $time);
        end
        comparisons++;
        if ({l3, pd, hiz, dis} !== {4{m_mode == 2}}) begin
            err_count++;
            $display("ERROR %0t model mismatch", $time);
        end
        @(posedge sys_clk);
    endtask : chk
    initial begin
        {rst, en, lvl, perst_n, ld, allow, seed} = {6'h21, 32'h0000_D18E};
        repeat (16) @(posedge sys_clk);
        rst <= 1'h0;
        step(0, 1, 0, 1, 8); chk(0);
        step(0, 1, 1, 0, 8); chk(0);
        $display("test refusals done");
        step(1, 1, 1, 1, 4); chk(0);
        step(0, 1, 0, 1, 2); chk(0);
        step(0, 1, 0, 1, 1); chk(1);
        step(0, 0, 0, 1, 6); chk(1);
        step(0, 1, 0, 1, 2); chk(0);
        step(0, 1, 1, 1, 3); chk(1);
        step(1, 1, 1, 1, 4); chk(0);
        $display("test entry and reread done");
        for (int i = 0; i < 20; i++) begin
            r = $random(seed);
            step(r[0], 1, 1, 1, 5); chk(~r[0]);
        end
        $display("test random request done");
        summarize();
    end
endmodule : ddc_top_bench
